// >>> include/eprgm_pkg.sv
// Purpose : shared constants and types for the program/verify port
// Assumes : one system clock; oscillator, reset pin and port levels arrive synchronous to it
// Notes   : all cycle figures below count oscillator periods, not system clocks
package eprgm_pkg;

	// serial mode code
	localparam int          MODE_BITS   = 10;
	localparam logic [9:0]  CODE_USER   = 10'h296;
	localparam logic [9:0]  CODE_KEY    = 10'h292;
	localparam logic [9:0]  CODE_SEC1   = 10'h29a;
	localparam logic [9:0]  CODE_SEC2   = 10'h298;

	// oscillator-period counts and the strobe pulse target
	localparam int          TICK_CNT_W         = 6;
	localparam logic [5:0]  ARM_TICKS          = 6'h18;  // two machine cycles of twelve periods
	localparam logic [5:0]  ADDR_SETTLE_TICKS  = 6'h0d;  // thirteen periods
	localparam logic [5:0]  VERIFY_TICKS       = 6'h30;  // four machine cycles, 48 periods
	localparam logic [4:0]  PULSE_TARGET       = 5'h19;  // strobe pulses in one program cycle

	// storage geometry
	localparam int          ADDR_W      = 11;
	localparam int          ADDR_HI_W   = 3;
	localparam int          USER_DEPTH  = 2048;
	localparam int          KEY_DEPTH   = 16;
	localparam int          KEY_IDX_W   = 4;
	localparam logic [7:0]  ERASED_BYTE = 8'hff;
	localparam logic [7:0]  BLANK_BYTE  = 8'h00;

	// security readout bit positions
	localparam int          SEC1_POS    = 7;
	localparam int          SEC2_POS    = 6;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARMED,
		ST_SHIFT,
		ST_PROG
	} eprgm_state_e;

endpackage

// >>> verilog/eprgm_shift.sv
// Purpose : serial mode code receiver, first bit lands in bit zero
// Assumes : shift_en is a one-cycle pulse per sampled bit
// Notes   : full stays high until clear; further shifts are ignored
`timescale 1ns/10ps
module eprgm_shift
	import eprgm_pkg::*;
(
	input  wire logic                 clock,
	input  wire logic                 sys_rst,
	input  wire logic                 clear,
	input  wire logic                 shift_en,
	input  wire logic                 bit_in,
	output logic      [MODE_BITS-1:0] code,
	output logic                      full
);

	logic [3:0] count_r;

	////////////////////////////////////////////////////////////////////////////
	// shift toward bit zero so the first bit ends up least significant
	always_ff @(posedge clock) begin
		if (sys_rst || clear) begin
			code    <= '0;
			count_r <= '0;
		end else if (shift_en && !full) begin
			code    <= {bit_in, code[MODE_BITS-1:1]};
			count_r <= count_r + 4'h1;
		end
	end

	assign full = (count_r == 4'(MODE_BITS));

endmodule

// >>> verilog/eprgm_delay.sv
// Purpose : counts oscillator ticks after a restart and flags when a target is reached
// Assumes : tick is a one-cycle pulse
// Notes   : done is a level; restart wins over a tick in the same cycle
`timescale 1ns/10ps
module eprgm_delay
	import eprgm_pkg::*;
#(
	parameter logic [TICK_CNT_W-1:0] TARGET = ADDR_SETTLE_TICKS
)(
	input  wire logic clock,
	input  wire logic sys_rst,
	input  wire logic restart,
	input  wire logic tick,
	output logic      done
);

	logic [TICK_CNT_W-1:0] count_r;

	////////////////////////////////////////////////////////////////////////////
	// saturating counter, so done holds until the next restart
	always_ff @(posedge clock) begin
		if (sys_rst || restart) begin
			count_r <= '0;
		end else if (tick && !done) begin
			count_r <= count_r + TICK_CNT_W'(1);
		end
	end

	assign done = (count_r == TARGET);

endmodule

// >>> verilog/eprgm_port.sv
// Purpose : program/verify port for the on-chip code array, key array and security bits
// Assumes : programmer pins arrive synchronous to clock; oscillator is far slower than clock
// Notes   : storage is nonvolatile, so sys_rst leaves arrays and security cells alone
//
// Summary of operation
// - programming mode entered by ten-bit serial code on reset pin, first bit least significant
// - each code bit sampled while oscillator input is high
// - falling address select latches upper bits; programmer holds them two cycles
// - full address stable 13 cycles after low byte, while held and select low
// - data port drives for verify, accepts write data while program voltage applied
// - verify data appears 48 oscillator cycles after program voltage returns normal
// - target chosen by mode code with strobe and program-voltage levels
// - user array verify output is stored byte XNOR one key byte
// - key byte chosen by code address modulo sixteen
// - security bit 1 blocks user and key writes and key verify
// - security bit 2 blocks user and key verify, security readout still allowed
// - codes: 296H user, 292H key, 29AH security 1 and readout, 298H security 2
// - security readout: bit 7 security 1, bit 6 security 2, one when programmed
// - erased user and key arrays hold all ones
`timescale 1ns/10ps
module eprgm_port
	import eprgm_pkg::*;
(
	input  wire logic                  clock,
	input  wire logic                  sys_rst,
	input  wire logic                  reset_pin,
	input  wire logic                  oscillator_input,
	input  wire logic                  address_byte_select,
	input  wire logic [7:0]            address_port,
	input  wire logic                  program_strobe_n,
	input  wire logic                  program_voltage_on,
	input  wire logic [7:0]            data_port_in,
	output logic      [7:0]            data_port_out,
	output logic                       data_port_oe,
	output logic                       prog_mode,
	output logic      [MODE_BITS-1:0]  mode_code,
	output logic      [4:0]            strobe_pulse_count,
	output logic                       write_refused
);

	eprgm_state_e            state_r;
	logic                    osc_prev_r;
	logic                    address_byte_select_prev_r;
	logic                    strobe_prev_r;
	logic [ADDR_HI_W-1:0]    addr_hi_r;
	logic [7:0]              addr_lo_r;
	logic [ADDR_W-1:0]       addr_r;
	logic [7:0]              user_mem [USER_DEPTH] = '{default: ERASED_BYTE}; // erased image
	logic [7:0]              key_mem [KEY_DEPTH] = '{default: ERASED_BYTE};
	logic                    sec1_prog_r = 1'b0; // nonvolatile, sys_rst never clears it
	logic                    sec2_prog_r = 1'b0;
	logic                    osc_tick;
	logic                    address_byte_select_fall;
	logic                    strobe_fall;
	logic                    shift_en;
	logic                    shift_clear;
	logic [MODE_BITS-1:0]    rx_code;
	logic                    rx_full;
	logic                    code_ok;
	logic                    arm_done;
	logic                    settle_done;
	logic                    verify_done;
	logic                    in_prog;
	logic                    prog_pulse;
	logic                    user_wr_en;
	logic                    key_wr_en;
	logic                    blocked_wr;
	logic [7:0]              user_byte;
	logic [7:0]              key_byte;
	logic [7:0]              view_byte;
	logic                    show_data;

	// every check samples on the system clock and sleeps through reset
	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	////////////////////////////////////////////////////////////////////////////
	// edge detection on the slow pins
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			osc_prev_r    <= 1'b0;
			address_byte_select_prev_r   <= 1'b0;
			strobe_prev_r <= 1'b1;
		end else begin
			osc_prev_r    <= oscillator_input;
			address_byte_select_prev_r   <= address_byte_select;
			strobe_prev_r <= program_strobe_n;
		end
	end

	// a tick is the first system clock of each oscillator high phase
	assign osc_tick    = oscillator_input && !osc_prev_r;
	assign address_byte_select_fall   = address_byte_select_prev_r && !address_byte_select;
	assign strobe_fall = strobe_prev_r && !program_strobe_n;
	assign in_prog     = (state_r == ST_PROG);

	////////////////////////////////////////////////////////////////////////////
	// mode entry: arm on a long high, then take ten bits starting with the first low
	eprgm_delay #(
		.TARGET (ARM_TICKS)
	) u_arm (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (!reset_pin),
		.tick    (osc_tick),
		.done    (arm_done)
	);

	// every valid code has a zero first bit, so the first low sample starts the frame
	assign shift_en    = osc_tick && ((state_r == ST_ARMED && !reset_pin) || state_r == ST_SHIFT);
	assign shift_clear = (state_r == ST_IDLE);

	eprgm_shift u_shift (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.clear    (shift_clear),
		.shift_en (shift_en),
		.bit_in   (reset_pin),
		.code     (rx_code),
		.full     (rx_full)
	);

	assign code_ok = (rx_code == CODE_USER) || (rx_code == CODE_KEY) ||
	                 (rx_code == CODE_SEC1) || (rx_code == CODE_SEC2);

	// session control; a high reset pin during a session drops back to idle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (arm_done) begin
						state_r <= ST_ARMED;
					end
				end
				ST_ARMED: begin
					if (shift_en) begin
						state_r <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (rx_full) begin
						state_r <= code_ok ? ST_PROG : ST_IDLE;
					end
				end
				ST_PROG: begin
					if (osc_tick && reset_pin) begin
						state_r <= ST_IDLE;
					end
				end
				default: begin
					state_r <= ST_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// address demultiplexing on one byte port
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_hi_r <= '0;
			addr_lo_r <= '0;
		end else begin
			if (address_byte_select_fall) begin
				addr_hi_r <= address_port[ADDR_HI_W-1:0];
			end
			addr_lo_r <= address_port;
		end
	end

	// any movement of the low byte or the select line restarts settling
	eprgm_delay #(
		.TARGET (ADDR_SETTLE_TICKS)
	) u_settle (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (address_byte_select || address_byte_select_fall || (address_port != addr_lo_r)),
		.tick    (osc_tick),
		.done    (settle_done)
	);

	// internal address only moves once the low byte has settled
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			addr_r <= '0;
		end else if (settle_done) begin
			addr_r <= {addr_hi_r, addr_lo_r};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// each strobe pulse can only clear bits, so 25 repeats are harmless
	assign prog_pulse = in_prog && program_voltage_on && strobe_fall && settle_done;
	assign user_wr_en = prog_pulse && (rx_code == CODE_USER) && !sec1_prog_r;
	assign key_wr_en  = prog_pulse && (rx_code == CODE_KEY) && !sec1_prog_r;
	assign blocked_wr = prog_pulse && sec1_prog_r && ((rx_code == CODE_USER) || (rx_code == CODE_KEY));

	always_ff @(posedge clock) begin
		if (user_wr_en) begin
			user_mem[addr_r] <= user_mem[addr_r] & data_port_in;
		end
	end

	always_ff @(posedge clock) begin
		if (key_wr_en) begin
			key_mem[addr_r[KEY_IDX_W-1:0]] <= key_mem[addr_r[KEY_IDX_W-1:0]] & data_port_in;
		end
	end

	// security cells need no address; sys_rst must never erase them
	always_ff @(posedge clock) begin
		if (in_prog && program_voltage_on && strobe_fall) begin
			if (rx_code == CODE_SEC1) begin
				sec1_prog_r <= 1'b1;
			end else if (rx_code == CODE_SEC2) begin
				sec2_prog_r <= 1'b1;
			end
		end
	end

	// pulse count per program cycle, restarted whenever the voltage drops
	always_ff @(posedge clock) begin
		if (sys_rst || !program_voltage_on) begin
			strobe_pulse_count <= '0;
		end else if (in_prog && strobe_fall && strobe_pulse_count != PULSE_TARGET) begin
			strobe_pulse_count <= strobe_pulse_count + 5'h01;
		end
	end

	// refused writes are reported until the program voltage drops
	always_ff @(posedge clock) begin
		if (sys_rst || !program_voltage_on) begin
			write_refused <= 1'b0;
		end else if (blocked_wr) begin
			write_refused <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// verify path
	eprgm_delay #(
		.TARGET (VERIFY_TICKS)
	) u_verify (
		.clock   (clock),
		.sys_rst (sys_rst),
		.restart (!in_prog || program_voltage_on || !settle_done),
		.tick    (osc_tick),
		.done    (verify_done)
	);

	assign user_byte = user_mem[addr_r];
	assign key_byte  = key_mem[addr_r[KEY_IDX_W-1:0]];

	// blocked reads show zeros rather than any stored bit
	always_comb begin
		view_byte = BLANK_BYTE;
		if (rx_code == CODE_USER && !sec2_prog_r) begin
			view_byte = ~(user_byte ^ key_byte);
		end else if (rx_code == CODE_KEY && !sec1_prog_r && !sec2_prog_r) begin
			view_byte = key_byte;
		end else if (rx_code == CODE_SEC1) begin
			view_byte[SEC1_POS] = sec1_prog_r;
			view_byte[SEC2_POS] = sec2_prog_r;
		end
	end

	assign show_data = in_prog && !program_voltage_on && verify_done;

	// port turns around only while the programming voltage is off
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			data_port_oe  <= 1'b0;
			data_port_out <= BLANK_BYTE;
		end else begin
			data_port_oe  <= in_prog && !program_voltage_on;
			data_port_out <= show_data ? view_byte : BLANK_BYTE;
		end
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			prog_mode <= 1'b0;
			mode_code <= '0;
		end else begin
			prog_mode <= in_prog;
			mode_code <= in_prog ? rx_code : '0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	sequence code_frame_done;
		state_r == ST_SHIFT ##0 rx_full ##0 code_ok;
	endsequence

	sequence verify_ready;
		in_prog && !program_voltage_on && verify_done;
	endsequence

	mode_entry_a: assert property (code_frame_done |=> in_prog ##1 prog_mode)
		else $error("valid mode code did not enter programming");
	sample_high_a: assert property (shift_en |-> oscillator_input && !osc_prev_r)
		else $error("mode bit sampled outside oscillator high");
	hi_latch_a: assert property (address_byte_select_fall |=> addr_hi_r == $past(address_port[ADDR_HI_W-1:0]))
		else $error("upper address not latched on select fall");
	addr_settle_a: assert property (!settle_done |=> $stable(addr_r))
		else $error("address moved before settling");
	port_dir_a: assert property (program_voltage_on |=> !data_port_oe)
		else $error("data port driven while program voltage on");
	verify_wait_a: assert property ($rose(data_port_out != BLANK_BYTE) |-> $past(verify_done))
		else $error("verify data before delay elapsed");
	user_xnor_a: assert property (verify_ready ##0 (rx_code == CODE_USER) ##0 !sec2_prog_r
		|=> data_port_out == ~($past(user_byte) ^ $past(key_byte)))
		else $error("user verify byte not key encrypted");
	write_block_a: assert property (prog_pulse && sec1_prog_r && (rx_code == CODE_USER || rx_code == CODE_KEY)
		|-> !user_wr_en && !key_wr_en ##1 write_refused)
		else $error("write not refused under security bit 1");
	read_block_a: assert property (verify_ready ##0 sec2_prog_r ##0 (rx_code != CODE_SEC1)
		|=> data_port_out == BLANK_BYTE)
		else $error("stored data shown under security bit 2");
	sec_readout_a: assert property (verify_ready ##0 (rx_code == CODE_SEC1)
		|=> data_port_out[SEC1_POS] == $past(sec1_prog_r) && data_port_out[SEC2_POS] == $past(sec2_prog_r))
		else $error("security readout bits wrong");

endmodule

// >>> dv/eprgm_prog_model.sv
// Purpose : programmer model driving the program/verify port pins
// Assumes : oscillator at a quarter of the system clock, 5 MHz
// Notes   : pins move only at falling clock edges; tb_top calls the tasks
`timescale 1ns/10ps
module eprgm_prog_model (
	input  wire logic       clock,
	output logic            oscillator_input,
	output logic            reset_pin,
	output logic            address_byte_select,
	output logic [7:0]      address_port,
	output logic            program_strobe_n,
	output logic            program_voltage_on,
	output logic [7:0]      data_port_in
);
	logic [1:0] osc_cnt = 2'h0;
	logic [7:0] wr_byte = 8'h00;
	logic [3:0] page    = 4'hf;

	////////////////////////////////////////////////////////////////////////
	// free-running oscillator, kept inside the legal band
	always @(negedge clock) begin
		osc_cnt <= osc_cnt + 2'h1;
	end
	assign oscillator_input = osc_cnt[1];
	// released lines show the inverse, so a stale byte never passes
	assign data_port_in = program_voltage_on ? wr_byte : ~wr_byte;

	// idle pin levels from time zero
	initial begin
		reset_pin = 1'b1;
		address_byte_select = 1'b0;
		address_port = 8'h00;
		program_strobe_n = 1'b1;
		program_voltage_on = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// each step ends while the oscillator is low
	task automatic ticks(input int n);
		repeat (n) @(negedge oscillator_input);
	endtask

	// arm, then shift the code first bit first
	task automatic enter(input logic [9:0] code);
		if (oscillator_input) ticks(1);
		program_strobe_n = 1'b1;
		program_voltage_on = 1'b0;
		reset_pin = 1'b1;
		page = 4'hf;
		ticks(26);
		for (int i = 0; i < 10; i++) begin
			reset_pin = code[i];
			ticks(1);
		end
		reset_pin = 1'b0;
	endtask

	// upper bits go out only when the page changes
	task automatic set_addr(input logic [10:0] a);
		if ({1'b0, a[10:8]} != page) begin
			address_byte_select = 1'b1;
			address_port = {5'h00, a[10:8]};
			ticks(14);
			address_byte_select = 1'b0;
			ticks(2);
			page = {1'b0, a[10:8]};
		end
		address_port = a[7:0];
		ticks(14);
	endtask

	// program voltage on, then the full pulse train
	task automatic burn_byte(input logic [7:0] d);
		wr_byte = d;
		program_voltage_on = 1'b1;
		ticks(2);
		repeat (25) begin
			program_strobe_n = 1'b0;
			ticks(2);
			program_strobe_n = 1'b1;
			ticks(2);
		end
	endtask

	// back to normal level, which starts a verify
	task automatic normal();
		program_voltage_on = 1'b0;
	endtask
endmodule

// >>> dv/tb_top.sv
// Purpose : self-checking bench for the program/verify port
// Assumes : programmer model drives all pins at falling clock edges
// Notes   : storage survives sys_rst, so the last case re-reads it
`timescale 1ns/10ps
module tb_top
	import eprgm_pkg::*;
;
	typedef struct packed {
		logic [9:0]  code;
		logic [10:0] addr;
		logic        prog;
		logic [7:0]  wdata;
		logic        refused;
		logic [7:0]  exp_d;
	} eprgm_row_s;

	logic                 clock = 1'b0;
	logic                 sys_rst = 1'b1;
	logic                 oscillator_input, reset_pin, address_byte_select;
	logic [7:0]           address_port, data_port_in, data_port_out;
	logic                 program_strobe_n, program_voltage_on;
	logic                 data_port_oe, prog_mode, write_refused;
	logic [MODE_BITS-1:0] mode_code;
	logic [4:0]           strobe_pulse_count;
	logic [9:0]           cur = 10'h000;
	int                   fail_count = 0;
	int                   cmp_count = 0;

	// storage order matters: one erased user read first, then key bytes before the other user reads, locks last
	eprgm_row_s rows [12] = '{
		'{CODE_USER, 11'h123, 1'b0, 8'h00, 1'b0, 8'hff},
		'{CODE_KEY,  11'h003, 1'b1, 8'h5a, 1'b0, 8'h5a},
		'{CODE_KEY,  11'h004, 1'b1, 8'h0f, 1'b0, 8'h0f},
		'{CODE_USER, 11'h213, 1'b1, 8'h3c, 1'b0, 8'h99},
		'{CODE_USER, 11'h214, 1'b0, 8'h00, 1'b0, 8'h0f},
		'{CODE_USER, 11'h223, 1'b0, 8'h00, 1'b0, 8'h5a},
		'{CODE_SEC1, 11'h000, 1'b1, 8'h00, 1'b0, 8'h80},
		'{CODE_USER, 11'h213, 1'b1, 8'h00, 1'b1, 8'h99},
		'{CODE_KEY,  11'h003, 1'b1, 8'h00, 1'b1, 8'h00},
		'{CODE_SEC2, 11'h000, 1'b1, 8'h00, 1'b0, 8'h00},
		'{CODE_SEC1, 11'h000, 1'b0, 8'h00, 1'b0, 8'hc0},
		'{CODE_USER, 11'h213, 1'b0, 8'h00, 1'b0, 8'h00}
	};

	////////////////////////////////////////////////////////////////////////
	// 20 MHz system clock
	always #25 clock = ~clock;

	eprgm_prog_model i_prog (
		.clock               (clock),
		.oscillator_input    (oscillator_input),
		.reset_pin           (reset_pin),
		.address_byte_select (address_byte_select),
		.address_port        (address_port),
		.program_strobe_n    (program_strobe_n),
		.program_voltage_on  (program_voltage_on),
		.data_port_in        (data_port_in)
	);

	eprgm_port i_dut (
		.clock               (clock),
		.sys_rst             (sys_rst),
		.reset_pin           (reset_pin),
		.oscillator_input    (oscillator_input),
		.address_byte_select (address_byte_select),
		.address_port        (address_port),
		.program_strobe_n    (program_strobe_n),
		.program_voltage_on  (program_voltage_on),
		.data_port_in        (data_port_in),
		.data_port_out       (data_port_out),
		.data_port_oe        (data_port_oe),
		.prog_mode           (prog_mode),
		.mode_code           (mode_code),
		.strobe_pulse_count  (strobe_pulse_count),
		.write_refused       (write_refused)
	);

	////////////////////////////////////////////////////////////////////////
	// compare with four-state equality, count every call
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
		cmp_count++;
		if (seen !== want) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic test_done();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// all outputs quiet, as after reset
	task automatic check_idle();
		check("idle", 32'({data_port_oe, data_port_out, prog_mode, mode_code, strobe_pulse_count, write_refused}), 0);
	endtask

	// bounded wait for the session flag
	task automatic enter(input logic [9:0] code);
		int n;
		i_prog.enter(code);
		n = 0;
		while (prog_mode !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		check("prog_mode", 32'(prog_mode), 1);
		check("mode_code", 32'(mode_code), 32'(code));
		cur = code;
		if (n == 20) test_done();
	endtask

	// one address, optional program cycle, then verify
	task automatic run_row(input eprgm_row_s r);
		if (r.code !== cur) enter(r.code);
		i_prog.set_addr(r.addr);
		if (r.prog) begin
			i_prog.burn_byte(r.wdata);
			check("oe_vpp", 32'(data_port_oe), 0);
			check("refused", 32'(write_refused), 32'(r.refused));
			if (!r.refused) check("pulses", 32'(strobe_pulse_count), 32'(PULSE_TARGET));
			i_prog.normal();
			i_prog.ticks(40);
			check("early", 32'(data_port_out), 0);
			check("oe_verify", 32'(data_port_oe), 1);
			i_prog.ticks(10);
		end else begin
			i_prog.ticks(50);
		end
		check("verify", 32'(data_port_out), 32'(r.exp_d));
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence: reset, table, then hand-written cases
	initial begin
		repeat (20) @(negedge clock);
		sys_rst = 1'b0;
		@(negedge clock);
		check_idle();
		foreach (rows[k]) begin
			run_row(rows[k]);
		end
		// unknown code must leave the session closed
		i_prog.enter(10'h294);
		i_prog.ticks(4);
		check("bad_code", 32'(prog_mode), 0);
		cur = 10'h000;
		// mid-session reset clears outputs but not the storage
		enter(CODE_USER);
		sys_rst = 1'b1;
		repeat (2) @(negedge clock);
		check_idle();
		sys_rst = 1'b0;
		cur = 10'h000;
		run_row('{CODE_SEC1, 11'h000, 1'b0, 8'h00, 1'b0, 8'hc0});
		test_done();
	end
endmodule
